// file: hdl/pic_controller.sv
`timescale 1ns/1ps
module pic_controller
  import pic_pkg::*;
#(
  parameter int          NUM_SRC     = 64,
  parameter logic [1:0]  FIXED_LEVEL = 2'h3
) (
  input  wire logic                core_clk,
  input  wire logic                reset,
  input  wire logic [23:0]         bus_addr,
  input  wire logic [15:0]         bus_wdata,
  input  wire logic                bus_write,
  input  wire logic                bus_read,
  output logic      [15:0]         bus_rdata,
  input  wire logic [NUM_SRC-1:0]  irq_request,
  input  wire logic                low_power_active,
  output pic_irq_out_t             irq_out,
  output logic      [1:0]          presented_level_code,
  output logic                     wake_request
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [15:0]        priority_levels [NUM_PRIO_REGS];
  logic [15:0]        next_priority_levels [NUM_PRIO_REGS];
  logic [15:0]        vector_base,        next_vector_base;
  logic [15:0]        fast_match_0,       next_fast_match_0;
  logic [15:0]        fast_vector_low_0,  next_fast_vector_low_0;
  logic [15:0]        fast_vector_high_0, next_fast_vector_high_0;
  logic [15:0]        fast_match_1,       next_fast_match_1;
  logic [15:0]        fast_vector_low_1,  next_fast_vector_low_1;
  logic [15:0]        fast_vector_high_1, next_fast_vector_high_1;
  logic [15:0]        next_bus_rdata;
  pic_mode_t          mode,               next_mode;
  logic [NUM_SRC-1:0] wake_enable,        next_wake_enable;
  pic_irq_out_t       next_irq_out;
  logic [1:0]         next_presented_level_code;
  logic               next_wake_request;

  logic [NUM_SRC-1:0] src_enabled;
  logic [1:0]         src_level [NUM_SRC];
  logic               hit;
  logic [4:0]         offset;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  // Only the 32-word window above the base belongs to this block.
  assign hit    = (bus_addr[23:5] == PIC_BASE[23:5]); // RL11
  assign offset = bus_addr[4:0]; // RL11

  // ---------------------------------------------------------------
  // Source levels
  // ---------------------------------------------------------------
  // The first priority register encodes levels 1 to 3, the others
  // levels 0 to 2; both use code zero as the disabled value.
  always_comb begin
    logic [1:0] field;
    field = CODE_DISABLED;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (i < NUM_PROG_SRC) begin
        // RL12 RL13 RL15 RL16 RL17 RL20 RL18
        field = priority_levels[i / FIELDS_PER_REG]
                [(15 - 2 * (i % FIELDS_PER_REG)) -: 2];
        src_enabled[i] = (field != CODE_DISABLED); // RL22
        src_level[i]   = (i < FIELDS_PER_REG) ? field
                                              : field - 2'h1;
      end else begin
        src_enabled[i] = 1'b1; // RL18
        src_level[i]   = FIXED_LEVEL;
      end
    end
  end

  // ---------------------------------------------------------------
  // Arbitration and vector
  // ---------------------------------------------------------------
  always_comb begin
    logic       found;
    logic [1:0] best_level;
    logic [5:0] best_src;
    logic [6:0] vec_num;
    found      = 1'b0;
    best_level = 2'h0;
    best_src   = 6'h00;
    vec_num    = 7'h00;
    // Scanning downward with >= lets a lower index take a tie.
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (irq_request[i] && src_enabled[i] && // RL22
          (!found || src_level[i] >= best_level)) begin // RL19 RL21
        found      = 1'b1;
        best_level = src_level[i];
        best_src   = 6'(i);
      end
    end
    vec_num = {1'b0, best_src};
    next_irq_out        = '0;
    next_irq_out.valid  = found;
    next_irq_out.level  = best_level;
    next_irq_out.source = best_src;
    next_irq_out.vector = {vector_base[ADDR_W-VEC_NUM_W-1:0],
                           vec_num}; // RL1
    // Fast match is resolved here so the address is ready at fetch.
    if (found && best_level == LEVEL_FAST) begin // RL6
      if (fast_match_0[VEC_NUM_W-1:0] == vec_num) begin // RL5
        next_irq_out.fast   = 1'b1;
        next_irq_out.vector = {fast_vector_high_0[4:0],
                               fast_vector_low_0};
      end else if (fast_match_1[VEC_NUM_W-1:0] == vec_num) begin // RL5
        next_irq_out.fast   = 1'b1;
        next_irq_out.vector = {fast_vector_high_1[4:0],
                               fast_vector_low_1};
      end
    end
    if (!found) begin
      next_irq_out.code = PCODE_NONE; // RL3
    end else begin
      case (best_level)
        2'h0:    next_irq_out.code = PCODE_LEVEL0; // RL3
        2'h1:    next_irq_out.code = PCODE_LEVEL1; // RL3
        default: next_irq_out.code = PCODE_LEVEL23; // RL3
      endcase
    end
    next_presented_level_code = next_irq_out.code;
  end

  // ---------------------------------------------------------------
  // Low-power mode and wake
  // ---------------------------------------------------------------
  always_comb begin
    next_mode         = mode;
    next_wake_enable  = wake_enable;
    next_wake_request = 1'b0;
    case (mode)
      ST_FUNCTIONAL: begin
        if (low_power_active) begin
          next_mode        = ST_LOW_POWER;
          next_wake_enable = src_enabled; // RL10
        end
      end
      ST_LOW_POWER: begin
        // Enables written while asleep cannot wake the core.
        next_wake_request = |(irq_request & wake_enable); // RL9 RL10
        if (!low_power_active) begin
          next_mode = ST_FUNCTIONAL;
        end
      end
      default: begin
        next_mode = ST_FUNCTIONAL;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------
  always_comb begin
    next_priority_levels    = priority_levels;
    next_vector_base        = vector_base;
    next_fast_match_0       = fast_match_0;
    next_fast_vector_low_0  = fast_vector_low_0;
    next_fast_vector_high_0 = fast_vector_high_0;
    next_fast_match_1       = fast_match_1;
    next_fast_vector_low_1  = fast_vector_low_1;
    next_fast_vector_high_1 = fast_vector_high_1;
    next_bus_rdata          = 16'h0000;
    if (hit && bus_write) begin
      if (offset <= OFS_PRIO_LAST) begin
        next_priority_levels[offset[2:0]] =
          (offset == OFS_PRIO_FIRST) ? (bus_wdata & PRIO0_WR_MASK)
                                     : bus_wdata; // RL14
      end
      case (offset)
        OFS_VECTOR_BASE: next_vector_base        = bus_wdata;
        OFS_FAST_MATCH0: next_fast_match_0       = bus_wdata; // RL4
        OFS_FAST_LOW0:   next_fast_vector_low_0  = bus_wdata;
        OFS_FAST_HIGH0:  next_fast_vector_high_0 = bus_wdata;
        OFS_FAST_MATCH1: next_fast_match_1       = bus_wdata; // RL4
        OFS_FAST_LOW1:   next_fast_vector_low_1  = bus_wdata;
        OFS_FAST_HIGH1:  next_fast_vector_high_1 = bus_wdata;
        default:         next_vector_base        = vector_base;
      endcase
    end
    if (hit && bus_read) begin
      if (offset <= OFS_PRIO_LAST) begin
        next_bus_rdata = priority_levels[offset[2:0]];
      end else if (offset >= OFS_PEND_FIRST &&
                   offset <= OFS_PEND_LAST) begin
        next_bus_rdata =
          16'(irq_request >> (16 * (offset - OFS_PEND_FIRST)));
      end else begin
        case (offset)
          OFS_VECTOR_BASE: next_bus_rdata = vector_base;
          OFS_FAST_MATCH0: next_bus_rdata = fast_match_0;
          OFS_FAST_LOW0:   next_bus_rdata = fast_vector_low_0;
          OFS_FAST_HIGH0:  next_bus_rdata = fast_vector_high_0;
          OFS_FAST_MATCH1: next_bus_rdata = fast_match_1;
          OFS_FAST_LOW1:   next_bus_rdata = fast_vector_low_1;
          OFS_FAST_HIGH1:  next_bus_rdata = fast_vector_high_1;
          OFS_CONTROL:     next_bus_rdata = {14'h0000,
                                             presented_level_code};
          default:         next_bus_rdata = 16'h0000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int r = 0; r < NUM_PRIO_REGS; r++) begin
        priority_levels[r] <= REG_RESET;
      end
      vector_base          <= REG_RESET;
      fast_match_0         <= REG_RESET;
      fast_vector_low_0    <= REG_RESET;
      fast_vector_high_0   <= REG_RESET;
      fast_match_1         <= REG_RESET;
      fast_vector_low_1    <= REG_RESET;
      fast_vector_high_1   <= REG_RESET;
      bus_rdata            <= REG_RESET;
      mode                 <= ST_FUNCTIONAL; // RL8
      wake_enable          <= '0;
      irq_out              <= '0;
      presented_level_code <= PCODE_NONE;
      wake_request         <= 1'b0;
    end else begin
      priority_levels      <= next_priority_levels;
      vector_base          <= next_vector_base;
      fast_match_0         <= next_fast_match_0;
      fast_vector_low_0    <= next_fast_vector_low_0;
      fast_vector_high_0   <= next_fast_vector_high_0;
      fast_match_1         <= next_fast_match_1;
      fast_vector_low_1    <= next_fast_vector_low_1;
      fast_vector_high_1   <= next_fast_vector_high_1;
      bus_rdata            <= next_bus_rdata;
      mode                 <= next_mode;
      wake_enable          <= next_wake_enable;
      irq_out              <= next_irq_out;
      presented_level_code <= next_presented_level_code;
      wake_request         <= next_wake_request;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_NORMAL_VECTOR: assert property (@(posedge core_clk) // RL1
    disable iff (reset) (irq_out.valid && !irq_out.fast) |->
    irq_out.vector == {$past(vector_base[ADDR_W-VEC_NUM_W-1:0]),
                       1'b0, irq_out.source})
    else $error("normal vector not base joined with number");

  AST_LEVEL_CODE: assert property (@(posedge core_clk) // RL3
    disable iff (reset)
    presented_level_code == (!irq_out.valid ? PCODE_NONE :
      irq_out.level == 2'h0 ? PCODE_LEVEL0 :
      irq_out.level == 2'h1 ? PCODE_LEVEL1 : PCODE_LEVEL23))
    else $error("presented level code wrong");

  AST_FAST_MATCH: assert property (@(posedge core_clk) // RL5
    disable iff (reset) irq_out.fast |->
    irq_out.level == LEVEL_FAST &&
    ($past(fast_match_0[6:0]) == {1'b0, irq_out.source} ||
     $past(fast_match_1[6:0]) == {1'b0, irq_out.source}))
    else $error("fast vector without level 2 match");

  AST_FAST_TAKEN: assert property (@(posedge core_clk) // RL6
    disable iff (reset) (next_irq_out.valid &&
    next_irq_out.level == LEVEL_FAST &&
    fast_match_0[6:0] == {1'b0, next_irq_out.source}) |=>
    irq_out.fast && irq_out.vector ==
    {$past(fast_vector_high_0[4:0]), $past(fast_vector_low_0)})
    else $error("fast slot 0 not substituted");

  AST_RESET_MODE: assert property (@(posedge core_clk) // RL8
    $past(reset) |-> mode == ST_FUNCTIONAL && !wake_request)
    else $error("not functional after reset");

  AST_WAKE: assert property (@(posedge core_clk) // RL9
    disable iff (reset) (mode == ST_LOW_POWER &&
    |(irq_request & wake_enable)) |=> wake_request)
    else $error("pending wake source did not request restart");

  AST_WAKE_ENABLED: assert property (@(posedge core_clk) // RL10
    disable iff (reset) wake_request |->
    $past(mode) == ST_LOW_POWER &&
    |($past(irq_request) & $past(wake_enable)))
    else $error("wake from source not enabled before sleep");

  AST_RESERVED: assert property (@(posedge core_clk) // RL14
    disable iff (reset) priority_levels[0][11:10] == 2'h0)
    else $error("reserved bits of first priority register set");

  AST_WINNER_ACTIVE: assert property (@(posedge core_clk) // RL22
    disable iff (reset) irq_out.valid |->
    1'(($past(irq_request) & $past(src_enabled)) >> irq_out.source))
    else $error("presented source inactive or disabled");

  AST_NO_BETTER: assert property (@(posedge core_clk) // RL19
    disable iff (reset) (next_irq_out.valid &&
    next_irq_out.source != 6'h00 && irq_request[0] &&
    src_enabled[0]) |-> src_level[0] < next_irq_out.level)
    else $error("source 0 lost a tie or to lower level");

endmodule

// file: hdl/pic_pkg.sv
// Operation
// RL1 - Normal vector joins base and vector number
// RL2 - Core masks levels with two status bits
// RL3 - Presented level reported as two-bit code
// RL4 - Software programs level 2, match, addresses
// RL5 - Level 2 match substitutes fast vector
// RL6 - Fast interrupt recognised here before core
// RL7 - Core enters fast handling unless subroutine jump
// RL8 - Functional mode is the reset mode
// RL9 - Pending request asks clock restart in sleep
// RL10 - Only requests enabled before sleep wake
// RL11 - Address is module base plus offset
// RL12 - Clock-loss level in bits 15-14
// RL13 - Low-supply level in bits 13-12
// RL14 - Reserved bits 11-10 written as zero
// RL15 - Debug receive-full level in bits 9-8
// RL16 - Debug transmit-empty level in bits 7-6
// RL17 - Debug trace level in bits 5-4
// RL18 - 64 sources, four levels, some fixed
// RL19 - Same level: lowest source number wins
// RL20 - Debug breakpoint level in bits 3-2
// RL21 - Highest level wins across levels
// RL22 - Disabled code makes a request inactive
package pic_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [23:0] PIC_BASE        = 24'h00f0e0;
  localparam logic [4:0]  OFS_PRIO_FIRST  = 5'h00;
  localparam logic [4:0]  OFS_PRIO_LAST   = 5'h06;
  localparam logic [4:0]  OFS_VECTOR_BASE = 5'h07;
  localparam logic [4:0]  OFS_FAST_MATCH0 = 5'h08;
  localparam logic [4:0]  OFS_FAST_LOW0   = 5'h09;
  localparam logic [4:0]  OFS_FAST_HIGH0  = 5'h0a;
  localparam logic [4:0]  OFS_FAST_MATCH1 = 5'h0b;
  localparam logic [4:0]  OFS_FAST_LOW1   = 5'h0c;
  localparam logic [4:0]  OFS_FAST_HIGH1  = 5'h0d;
  localparam logic [4:0]  OFS_PEND_FIRST  = 5'h0e;
  localparam logic [4:0]  OFS_PEND_LAST   = 5'h11;
  localparam logic [4:0]  OFS_CONTROL     = 5'h16;
  localparam logic [15:0] PRIO0_WR_MASK   = 16'hf3ff;
  localparam logic [15:0] REG_RESET       = 16'h0000;

  // ---------------------------------------------------------------
  // Priority encodings
  // ---------------------------------------------------------------
  localparam int          NUM_PRIO_REGS   = 7;
  localparam int          FIELDS_PER_REG  = 8;
  localparam int          NUM_PROG_SRC    = NUM_PRIO_REGS * FIELDS_PER_REG;
  localparam logic [1:0]  CODE_DISABLED   = 2'h0;
  localparam logic [1:0]  LEVEL_FAST      = 2'h2;
  localparam logic [1:0]  PCODE_NONE      = 2'h0;
  localparam logic [1:0]  PCODE_LEVEL0    = 2'h1;
  localparam logic [1:0]  PCODE_LEVEL1    = 2'h2;
  localparam logic [1:0]  PCODE_LEVEL23   = 2'h3;
  localparam int          VEC_NUM_W       = 7;
  localparam int          ADDR_W          = 21;

  typedef enum logic [1:0] {
    ST_FUNCTIONAL = 2'b01,
    ST_LOW_POWER  = 2'b10
  } pic_mode_t;

  typedef struct packed {
    logic                 valid;
    logic [1:0]           level;
    logic [1:0]           code;
    logic                 fast;
    logic [5:0]           source;
    logic [ADDR_W-1:0]    vector;
  } pic_irq_out_t;

endpackage

// file: verification/pic_core_model.sv
`timescale 1ns/1ps
module pic_core_model
  import pic_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire pic_irq_out_t irq_out,
  input  wire logic         wake_request,
  input  wire logic [1:0]   mask,
  input  wire logic         sleep_cmd,
  input  wire logic         subroutine_jump,
  output logic              low_power_active,
  output logic              accepted,
  output logic              fast_entry
);
  // ---------------------------------------------------------------
  // Core acceptance and sleep state
  // ---------------------------------------------------------------
  logic next_low_power;

  assign accepted   = irq_out.valid && (irq_out.level >= mask);
  assign fast_entry = accepted && irq_out.fast && !subroutine_jump;

  // Sleep is left only on the controller's restart request or on reset, as the
  // clock unit would do; a missing request leaves the core asleep.
  always_comb begin
    next_low_power = low_power_active;
    if (sleep_cmd) begin
      next_low_power = 1'b1;
    end else if (wake_request) begin
      next_low_power = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      low_power_active <= 1'b0;
    end else begin
      low_power_active <= next_low_power;
    end
  end
endmodule

// file: verification/tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %0t got %h want %h", $time, g, e); end end
module tb;
  import pic_pkg::*;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic         core_clk  = 1'b0;
  logic         reset     = 1'b1;
  logic [23:0]  bus_addr  = 24'h000000;
  logic [15:0]  bus_wdata = 16'h0000;
  logic         bus_write = 1'b0;
  logic         bus_read  = 1'b0;
  logic [15:0]  bus_rdata;
  logic [63:0]  irq_request = 64'h0;
  logic         low_power_active, wake_request, accepted, fast_entry;
  logic         sleep_cmd = 1'b0;
  logic         subroutine_jump = 1'b0;
  logic [1:0]   mask      = 2'h0;
  logic [1:0]   presented_level_code;
  pic_irq_out_t irq_out;
  int           n_fail, n_checks, cycles;

  always #12.5 core_clk = ~core_clk;

  pic_controller i_pic_controller (.core_clk(core_clk), .reset(reset),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write),
    .bus_read(bus_read), .bus_rdata(bus_rdata),
    .irq_request(irq_request), .low_power_active(low_power_active),
    .irq_out(irq_out), .presented_level_code(presented_level_code),
    .wake_request(wake_request));

  pic_core_model i_pic_core_model (.core_clk(core_clk), .reset(reset),
    .irq_out(irq_out), .wake_request(wake_request), .mask(mask),
    .sleep_cmd(sleep_cmd), .subroutine_jump(subroutine_jump),
    .low_power_active(low_power_active), .accepted(accepted),
    .fast_entry(fast_entry));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic end_of_test;
    if (n_fail == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Every access leaves one idle cycle so a strobe never toggles twice
  // in one time step between back-to-back calls.
  task automatic wr(input logic [7:0] o, input logic [15:0] d);
    bus_addr  = PIC_BASE + 24'(o);
    bus_wdata = d;
    bus_write = 1'b1;
    @(negedge core_clk);
    bus_write = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic rd(input logic [7:0] o, input logic [15:0] e);
    bus_addr = PIC_BASE + 24'(o);
    bus_read = 1'b1;
    @(negedge core_clk);
    bus_read = 1'b0;
    `CHK(bus_rdata, e)
    @(negedge core_clk);
  endtask

  task automatic req(input int i, input logic v);
    irq_request[i] = v;
    @(negedge core_clk);
  endtask

  task automatic chk_irq(input logic [5:0] s, input logic [1:0] l,
                         input logic [1:0] c);
    `CHK(irq_out.valid, 1'b1)
    `CHK(irq_out.source, s)
    `CHK(irq_out.level, l)
    `CHK(irq_out.code, c)
    `CHK(presented_level_code, c)
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    rd(8'h00, 16'h0000);
    rd(8'h16, 16'h0000);
    `CHK(irq_out, '0)
    wr(8'h07, 16'h1234);
    rd(8'h07, 16'h1234);
    wr(8'h00, 16'hffff);
    rd(8'h00, 16'hf3ff);
    wr(8'h12, 16'h5555);
    rd(8'h12, 16'h0000);
    rd(8'h47, 16'h0000);
    wr(8'h0e, 16'hffff);
    rd(8'h0e, 16'h0000);
    irq_request[17] = 1'b1;
    rd(8'h0f, 16'h0002);
    irq_request[17] = 1'b0;
    wr(8'h00, 16'h0000);
    wr(8'h07, 16'h0000);
  endtask

  task automatic t_levels;
    for (int s = 0; s < 7; s++) begin
      if (s == 2) begin
        continue;
      end
      for (int c = 1; c < 4; c++) begin
        wr(8'h00, 16'(c << (14 - 2 * s)));
        req(s, 1'b1);
        chk_irq(6'(s), 2'(c), {1'b1, c > 1});
        req(s, 1'b0);
      end
    end
    wr(8'h00, 16'h0000);
    for (int c = 1; c < 4; c++) begin
      wr(8'h01, 16'(c << 14));
      req(8, 1'b1);
      chk_irq(6'd8, 2'(c - 1), 2'(c));
      req(8, 1'b0);
    end
  endtask

  task automatic t_arb;
    wr(8'h07, 16'h0005);
    wr(8'h00, 16'h0100);
    wr(8'h01, 16'hf000);
    mask = 2'h2;
    irq_request[3] = 1'b1;
    irq_request[9] = 1'b1;
    req(8, 1'b1);
    chk_irq(6'd8, 2'h2, 2'h3);
    `CHK(irq_out.vector, {14'h0005, 1'b0, 6'd8})
    `CHK(accepted, 1'b1)
    rd(8'h16, 16'h0003);
    req(8, 1'b0);
    chk_irq(6'd9, 2'h2, 2'h3);
    req(9, 1'b0);
    chk_irq(6'd3, 2'h1, 2'h2);
    `CHK(accepted, 1'b0)
    mask = 2'h0;
    req(3, 1'b0);
  endtask

  task automatic t_fast;
    wr(8'h08, 16'h0009);
    wr(8'h09, 16'hbeef);
    wr(8'h0a, 16'h0013);
    req(9, 1'b1);
    `CHK(irq_out.fast, 1'b1)
    `CHK(irq_out.vector, 21'h13beef)
    `CHK(fast_entry, 1'b1)
    subroutine_jump = 1'b1;
    #1;
    `CHK(fast_entry, 1'b0)
    subroutine_jump = 1'b0;
    wr(8'h01, 16'he000);
    `CHK(irq_out.fast, 1'b0)
    `CHK(irq_out.vector, {14'h0005, 1'b0, 6'd9})
    req(9, 1'b0);
    wr(8'h0b, 16'h0008);
    wr(8'h0c, 16'h1111);
    wr(8'h0d, 16'h0002);
    req(8, 1'b1);
    `CHK(irq_out.vector, 21'h021111)
    wr(8'h01, 16'h0000);
    `CHK(irq_out.valid, 1'b0)
    req(8, 1'b0);
    req(60, 1'b1);
    chk_irq(6'd60, 2'h3, 2'h3);
    req(60, 1'b0);
  endtask

  task automatic t_wake;
    wr(8'h00, 16'h1000);
    sleep_cmd = 1'b1;
    @(negedge core_clk);
    sleep_cmd = 1'b0;
    repeat (2) @(negedge core_clk);
    req(1, 1'b1);
    `CHK(wake_request, 1'b1)
    req(1, 1'b0);
    wr(8'h00, 16'h0000);
    sleep_cmd = 1'b1;
    @(negedge core_clk);
    sleep_cmd = 1'b0;
    repeat (2) @(negedge core_clk);
    wr(8'h00, 16'h1000);
    req(1, 1'b1);
    @(negedge core_clk);
    `CHK(wake_request, 1'b0)
    req(1, 1'b0);
  endtask

  // A reset in mid-run, taken while asleep, must drop low-power mode
  // and every setting, or an always-enabled source would still wake.
  task automatic t_reset;
    reset = 1'b1;
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    `CHK(irq_out, '0)
    `CHK(wake_request, 1'b0)
    req(60, 1'b1);
    `CHK(wake_request, 1'b0)
    req(60, 1'b0);
    rd(8'h00, 16'h0000);
    rd(8'h08, 16'h0000);
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_fail++;
      end_of_test();
    end
  end

  initial begin
    repeat (20) @(negedge core_clk);
    reset = 1'b0;
    t_regs();
    t_levels();
    t_arb();
    t_fast();
    t_wake();
    t_reset();
    end_of_test();
  end
endmodule
